// ==== logic/rmad_alias_decode.sv ====
// Address decode of one write to the mapping and link-layer windows
`timescale 1ns/100ps
`default_nettype none
module rmad_alias_decode
(
  // Request
  input  wire logic [19:0] addr,
  input  wire logic        wr,
  input  wire logic        alias_en,
  // Decode
  output logic             map_hit,
  output logic             link_hit,
  output logic             map_wr,
  output logic             link_wr,
  output logic [8:0]       idx
);
  import rmad_pkg::*;

  assign map_hit  = rmad_in_win(addr, RMAD_MAP_LO, RMAD_MAP_HI);
  assign link_hit = rmad_in_win(addr, RMAD_LINK_LO, RMAD_LINK_HI);
  // Both windows share the low 12 bits, so one index serves both
  assign idx      = rmad_word_idx(addr);
  assign link_wr  = wr && link_hit;
  // Link writes also land in the mapping word with the same low bits
  assign map_wr   = wr && (map_hit || (link_hit && alias_en));
endmodule // rmad_alias_decode
`default_nettype wire

// ==== logic/rmad_pkg.sv ====
// Package: offsets, fields and reset values of the register alias decode block
package rmad_pkg;

  localparam int unsigned RMAD_ADDR_W = 20;

  // Lower mapping window and upper link-layer window, byte offsets
  localparam logic [19:0] RMAD_MAP_LO       = 20'h00400;
  localparam logic [19:0] RMAD_MAP_HI       = 20'h009FC;
  localparam logic [19:0] RMAD_LINK_LO      = 20'h1B400;
  localparam logic [19:0] RMAD_LINK_HI      = 20'h1B9FC;
  localparam logic [19:0] RMAD_LINK_BASE    = 20'h1B000;
  localparam int unsigned RMAD_ALIAS_BITS   = 12;

  // Named registers from the table
  localparam logic [19:0] RMAD_INBOUND_MAP_01_HIGH  = 20'h00410;
  localparam logic [19:0] RMAD_INBOUND_MAP_12_LOW   = 20'h00490;
  localparam logic [19:0] RMAD_INBOUND_MAP_22_QUEUE = 20'h00510;
  localparam logic [19:0] RMAD_TYPE9_MAP_45_WORD2   = 20'h00924;
  localparam logic [19:0] RMAD_TYPE9_MAP_47_WORD0   = 20'h00934;
  localparam logic [19:0] RMAD_TYPE9_MAP_47_WORD2   = 20'h0093C;
  localparam logic [19:0] RMAD_TYPE9_MAP_49_WORD0   = 20'h0094C;
  localparam logic [19:0] RMAD_TYPE9_MAP_49_WORD1   = 20'h00950;
  localparam logic [19:0] RMAD_TYPE9_MAP_50_WORD2   = 20'h00960;
  localparam logic [19:0] RMAD_TYPE9_MAP_52_WORD0   = 20'h00970;
  localparam logic [19:0] RMAD_TRANSPORT_PORT1_STATUS       = 20'h1B410;
  localparam logic [19:0] RMAD_TRANSPORT_PORT2_STATUS       = 20'h1B490;
  localparam logic [19:0] RMAD_TRANSPORT_PORT3_STATUS       = 20'h1B510;
  localparam logic [19:0] RMAD_EVENT_PORTWRITE_ENABLE       = 20'h1B924;
  localparam logic [19:0] RMAD_EVENT_DEVICE_PORTWRITE_ENABLE = 20'h1B934;
  localparam logic [19:0] RMAD_EVENT_MULTICAST_STATUS       = 20'h1B93C;
  localparam logic [19:0] RMAD_EVENT_MULTICAST_REQUEST      = 20'h1B94C;
  localparam logic [19:0] RMAD_EVENT_MULTICAST_PORT_STATUS  = 20'h1B950;
  localparam logic [19:0] RMAD_EVENT_RESET_PORT_STATUS      = 20'h1B960;
  localparam logic [19:0] RMAD_EVENT_RESET_PORTWRITE_ENABLE = 20'h1B970;

  // Block control and status, own offsets
  localparam logic [19:0] RMAD_CTRL_OFS     = 20'h00000;
  localparam logic [19:0] RMAD_STAT_OFS     = 20'h00004;
  localparam int unsigned RMAD_CTRL_ALIAS_EN = 0;

  // Pool of receive contexts and transfer-type field of a mapping entry
  localparam int unsigned RMAD_RX_CONTEXTS  = 16;
  localparam int unsigned RMAD_TT_LSB       = 13;
  localparam logic [1:0]  RMAD_TT_DISABLED  = 2'h3;

  // Word count of each window
  localparam int unsigned RMAD_WIN_WORDS    = 384;
  localparam int unsigned RMAD_WIN_IDX_W    = 9;

  localparam logic [31:0] RMAD_RESET_WORD   = 32'h0000_0000;
  localparam logic [31:0] RMAD_CTRL_RESET   = 32'h0000_0001;

  typedef enum logic [2:0]
  {
    RMAD_ST_IDLE  = 3'b001,
    RMAD_ST_WRITE = 3'b010,
    RMAD_ST_READ  = 3'b100
  } rmad_state_t;

  // Word index inside a window
  function automatic logic [8:0] rmad_word_idx(input logic [19:0] ofs);
    logic [11:0] low;
    low = ofs[11:0] - RMAD_MAP_LO[11:0];
    return low[10:2];
  endfunction

  function automatic logic rmad_in_win(input logic [19:0] a, input logic [19:0] lo,
                                       input logic [19:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

endpackage : rmad_pkg

// ==== logic/rmad_reg_bank.sv ====
// Register bank with AHB-Lite slave, mapping window and aliased link-layer window
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - A write in the link-layer window 1B400h-1B9FCh also writes the mapping word with equal low 12 bits.
// - The device holds a pool of sixteen receive contexts shared by all inbound messages.
// - Link-layer registers 1B490h to 1B970h alias mapping words at 00490h to 00970h.
// - Writes to 1B410h and 1B950h pass straight into mapping words 00410h and 00950h.
module rmad_reg_bank
(
  // Clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [19:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Receive context pool
  input  wire logic        ctx_claim,
  input  wire logic        ctx_release,
  output logic      [4:0]  ctx_free,
  // Mapping entry transfer types for the receive unit
  output logic      [1:0]  map01_tt,
  output logic      [1:0]  map49_tt
);
  import rmad_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address phase capture
  rmad_state_t state_reg;
  rmad_state_t state_next;
  logic [19:0] addr_reg;
  logic        ctrl_alias_reg;
  logic [4:0]  ctx_free_reg;
  logic [31:0] hrdata_reg;
  logic [1:0]  map01_tt_reg;
  logic [1:0]  map49_tt_reg;

  wire take_req = hsel && hready && htrans[1];
  wire is_wr_ph = (state_reg == RMAD_ST_WRITE);
  wire is_rd_ph = (state_reg == RMAD_ST_READ);

  always_comb
  begin
    state_next = RMAD_ST_IDLE;
    case (1'b1)
      take_req && hwrite:  state_next = RMAD_ST_WRITE;
      take_req && !hwrite: state_next = RMAD_ST_READ;
      default:             state_next = RMAD_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= RMAD_ST_IDLE;
      addr_reg  <= '0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      if (take_req)
      begin
        addr_reg <= {haddr[19:2], 2'h0};
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and banks
  logic       map_hit;
  logic       link_hit;
  logic       map_wr;
  logic       link_wr;
  logic [8:0] win_idx;
  logic [8:0] rd_idx;
  logic [31:0] map_rd;
  logic [31:0] link_rd;

  rmad_alias_decode u_dec
  (
    .addr     (addr_reg),
    .wr       (is_wr_ph),
    .alias_en (ctrl_alias_reg),
    .map_hit  (map_hit),
    .link_hit (link_hit),
    .map_wr   (map_wr),
    .link_wr  (link_wr),
    .idx      (win_idx)
  );

  // Read data registered, so decode the read at the address phase
  assign rd_idx = rmad_word_idx(haddr);

  rmad_word_bank u_map
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .wr_en   (map_wr),
    .wr_idx  (win_idx),
    .wr_data (hwdata),
    .rd_idx  (rd_idx),
    .rd_data (map_rd)
  );

  rmad_word_bank u_link
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .wr_en   (link_wr),
    .wr_idx  (win_idx),
    .wr_data (hwdata),
    .rd_idx  (rd_idx),
    .rd_data (link_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control, status, context pool
  wire ctrl_wr = is_wr_ph && (addr_reg == RMAD_CTRL_OFS);
  wire ctx_up  = ctx_release && (ctx_free_reg < 5'(RMAD_RX_CONTEXTS));
  wire ctx_dn  = ctx_claim && (ctx_free_reg != 5'h00);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ctrl_alias_reg <= RMAD_CTRL_RESET[RMAD_CTRL_ALIAS_EN];
      ctx_free_reg   <= 5'(RMAD_RX_CONTEXTS);
    end
    else if (clk_en)
    begin
      if (ctrl_wr)
      begin
        ctrl_alias_reg <= hwdata[RMAD_CTRL_ALIAS_EN];
      end
      // Claim and release in one cycle cancel, except at an empty pool (release counts) or a full pool (claim counts)
      if (ctx_up && !ctx_dn)
      begin
        ctx_free_reg <= ctx_free_reg + 5'h01;
      end
      else if (ctx_dn && !ctx_up)
      begin
        ctx_free_reg <= ctx_free_reg - 5'h01;
      end
    end
  end

  assign ctx_free = ctx_free_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, taken at the address phase
  logic [31:0] rd_word;
  wire rd_map  = rmad_in_win(haddr, RMAD_MAP_LO, RMAD_MAP_HI);
  wire rd_link = rmad_in_win(haddr, RMAD_LINK_LO, RMAD_LINK_HI);
  wire rd_ctrl = (haddr[19:2] == RMAD_CTRL_OFS[19:2]);
  wire rd_stat = (haddr[19:2] == RMAD_STAT_OFS[19:2]);
  // A window write in the data phase is visible to a read issued right behind it
  wire fwd_map  = map_wr && (win_idx == rd_idx) && rd_map;
  wire fwd_link = link_wr && (win_idx == rd_idx) && rd_link;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (rd_map)
    begin
      rd_word = fwd_map ? hwdata : map_rd;
    end
    else if (rd_link)
    begin
      rd_word = fwd_link ? hwdata : link_rd;
    end
    else if (rd_ctrl)
    begin
      rd_word = {31'h0000_0000, ctrl_alias_reg};
    end
    else if (rd_stat)
    begin
      rd_word = {27'h000_0000, ctx_free_reg};
    end
  end

  // Transfer-type fields of the two directly aliased entries
  wire wr01 = map_wr && (win_idx == rmad_word_idx(RMAD_INBOUND_MAP_01_HIGH));
  wire wr49 = map_wr && (win_idx == rmad_word_idx(RMAD_TYPE9_MAP_49_WORD1));

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      hrdata_reg   <= 32'h0000_0000;
      map01_tt_reg <= 2'h0;
      map49_tt_reg <= 2'h0;
    end
    else if (clk_en)
    begin
      if (take_req && !hwrite)
      begin
        hrdata_reg <= rd_word;
      end
      if (wr01)
      begin
        map01_tt_reg <= hwdata[RMAD_TT_LSB+1:RMAD_TT_LSB];
      end
      if (wr49)
      begin
        map49_tt_reg <= hwdata[RMAD_TT_LSB+1:RMAD_TT_LSB];
      end
    end
  end

  assign hrdata   = hrdata_reg;
  assign map01_tt = map01_tt_reg;
  assign map49_tt = map49_tt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_alias_copy: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && link_wr && ctrl_alias_reg) |-> map_wr)
    else $error("link write not copied to mapping word");

  a_no_side_effect: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (map_wr && !map_hit) |-> (link_hit && ctrl_alias_reg))
    else $error("mapping word written from outside the window");

  a_port1_passthru: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && is_wr_ph && ctrl_alias_reg && addr_reg == RMAD_TRANSPORT_PORT1_STATUS)
    |=> (map01_tt == $past(hwdata[14:13])))
    else $error("port1 status did not reach mapping 01 field");

  a_mcast_passthru: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && is_wr_ph && ctrl_alias_reg && addr_reg == RMAD_EVENT_MULTICAST_PORT_STATUS)
    |=> (map49_tt == $past(hwdata[14:13])))
    else $error("multicast port status did not reach mapping 49 field");

  a_pair_index: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (link_wr && addr_reg == RMAD_EVENT_PORTWRITE_ENABLE)
    |-> (win_idx == rmad_word_idx(RMAD_TYPE9_MAP_45_WORD2)))
    else $error("1B924h not paired with 00924h");

  a_ctx_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctx_free <= 5'd16)
    else $error("context pool above sixteen");

  a_ctx_claim: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && ctx_claim && !ctx_release && ctx_free != 5'd0)
    |=> (ctx_free == $past(ctx_free) - 5'd1))
    else $error("context claim not counted");

  a_map_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (is_wr_ph && map_hit) |-> (map_wr && !link_wr))
    else $error("mapping write leaked into link window");

  a_fixed_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (is_wr_ph && link_hit && !ctrl_alias_reg) |-> !map_wr)
    else $error("link write reached mapping word with alias off");

  a_read_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_rd_ph |-> (!map_wr && !link_wr))
    else $error("read data phase wrote a window word");

  a_ctx_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && ctx_release && !ctx_claim && ctx_free < 5'h10)
    |=> (ctx_free == $past(ctx_free) + 5'h01))
    else $error("context release not counted");

  a_ctx_cancel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && ctx_claim && ctx_release && ctx_free != 5'h00 && ctx_free < 5'h10)
    |=> $stable(ctx_free))
    else $error("claim and release in one cycle moved the pool");

  a_frozen_state: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !clk_en |=> ($stable(ctx_free) && $stable(hrdata) && $stable(map01_tt)))
    else $error("state moved while clock enable low");

  a_tt01_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(clk_en && wr01) |=> $stable(map01_tt))
    else $error("mapping 01 field changed without a write");

  a_tt49_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(clk_en && wr49) |=> $stable(map49_tt))
    else $error("mapping 49 field changed without a write");
endmodule // rmad_reg_bank
`default_nettype wire

// ==== logic/rmad_word_bank.sv ====
// Word memory of one register window with one write and one read port
`timescale 1ns/100ps
`default_nettype none
module rmad_word_bank
(
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  // Write port
  input  wire logic                          wr_en,
  input  wire logic [rmad_pkg::RMAD_WIN_IDX_W-1:0] wr_idx,
  input  wire logic [31:0]                   wr_data,
  // Read port
  input  wire logic [rmad_pkg::RMAD_WIN_IDX_W-1:0] rd_idx,
  output logic      [31:0]                   rd_data
);
  import rmad_pkg::*;

  logic [31:0] mem_reg [RMAD_WIN_WORDS];
  logic [RMAD_WIN_WORDS-1:0] written_reg;

  // Never-written words read as reset value, avoiding a reset loop over memory
  assign rd_data = written_reg[rd_idx] ? mem_reg[rd_idx] : RMAD_RESET_WORD;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      written_reg <= '0;
    end
    else if (clk_en && wr_en)
    begin
      written_reg[wr_idx] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (clk_en && wr_en)
    begin
      mem_reg[wr_idx] <= wr_data;
    end
  end
endmodule // rmad_word_bank
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking testbench of the register alias decode bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rmad_pkg::*;

  logic        ref_clk     = 1'b0;
  logic        rst_n       = 1'b0;
  logic        clk_en      = 1'b1;
  logic        hsel        = 1'b0;
  logic [19:0] haddr       = 20'h00000;
  logic [1:0]  htrans      = 2'h0;
  logic        hwrite      = 1'b0;
  logic [2:0]  hsize       = 3'h2;
  logic [31:0] hwdata      = 32'h0;
  logic        ctx_claim   = 1'b0;
  logic        ctx_release = 1'b0;
  wire logic        hreadyout;
  wire logic        hresp;
  wire logic [31:0] hrdata;
  wire logic [4:0]  ctx_free;
  wire logic [1:0]  map01_tt;
  wire logic [1:0]  map49_tt;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          cycles      = 0;
  logic [31:0] exp_q[$];
  logic        rd_phase    = 1'b0;
  logic [31:0] link_val [10];
  logic [19:0] ofs;
  logic [31:0] d;
  // The block sits at base zero on this bench
  localparam logic [19:0] BASE_ADDR = 20'h00000;
  localparam logic [19:0] LINK_OFS [10] = '{RMAD_TRANSPORT_PORT1_STATUS,
    RMAD_TRANSPORT_PORT2_STATUS, RMAD_TRANSPORT_PORT3_STATUS, RMAD_EVENT_PORTWRITE_ENABLE,
    RMAD_EVENT_DEVICE_PORTWRITE_ENABLE, RMAD_EVENT_MULTICAST_STATUS,
    RMAD_EVENT_MULTICAST_REQUEST, RMAD_EVENT_MULTICAST_PORT_STATUS,
    RMAD_EVENT_RESET_PORT_STATUS, RMAD_EVENT_RESET_PORTWRITE_ENABLE};

  rmad_reg_bank i_dut
  (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .hsel        (hsel),
    .haddr       (haddr),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (hsize),
    .hwdata      (hwdata),
    .hready      (hreadyout),
    .hreadyout   (hreadyout),
    .hresp       (hresp),
    .hrdata      (hrdata),
    .ctx_claim   (ctx_claim),
    .ctx_release (ctx_release),
    .ctx_free    (ctx_free),
    .map01_tt    (map01_tt),
    .map49_tt    (map49_tt)
  );

  always #4 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Single word transfer; waits are cut short only by the cycle ceiling
  task automatic ahb(input logic wr, input logic [19:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= BASE_ADDR + a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : hwdata;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
  endtask

  task automatic rd(input logic [19:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    ahb(1'b0, a, 32'h0);
  endtask

  task automatic ctx(input logic c, input logic r, input int n, input logic [4:0] exp);
    @(posedge ref_clk);
    ctx_claim <= c;
    ctx_release <= r;
    repeat (n) @(posedge ref_clk);
    ctx_claim <= 1'b0;
    ctx_release <= 1'b0;
    @(negedge ref_clk);
    check({27'h0, ctx_free}, {27'h0, exp});
  endtask

  function automatic logic [19:0] map_of(input logic [19:0] a);
    return {8'h00, a[11:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Read data checked at the edge that ends the data phase
  always @(posedge ref_clk)
  begin
    if (rd_phase && hreadyout)
    begin
      check({31'h0, hresp}, 32'h0);
      check({31'h0, hreadyout}, 32'h1);
      if (exp_q.size() == 0)
        check(hrdata, ~hrdata);
      else
        check(hrdata, exp_q.pop_front());
    end
    if (hreadyout)
      rd_phase <= hsel && htrans[1] && !hwrite && clk_en && rst_n;
  end

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h6f882b5b));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(RMAD_CTRL_OFS, RMAD_CTRL_RESET);
    rd(RMAD_STAT_OFS, 32'h10);
    // Transfer types first written through the link alias, then direct write to a mapping word
    ahb(1'b1, RMAD_TRANSPORT_PORT1_STATUS, 32'h0000_2000);
    ahb(1'b1, RMAD_TYPE9_MAP_49_WORD1, 32'h0000_4000);
    @(negedge ref_clk);
    check({30'h0, map01_tt}, 32'h1);
    check({30'h0, map49_tt}, 32'h2);
    for (int i = 0; i < 10; i++)
    begin
      if (i != 0 && i != 7)
        rd(map_of(LINK_OFS[i]), RMAD_RESET_WORD);
      link_val[i] = $urandom();
      if (i == 0 || i == 7)
        link_val[i][14:13] = 2'h3;
      ahb(1'b1, LINK_OFS[i], link_val[i]);
      rd(LINK_OFS[i], link_val[i]);
      rd(map_of(LINK_OFS[i]), link_val[i]);
    end
    @(negedge ref_clk);
    check({30'h0, map01_tt}, 32'h3);
    check({30'h0, map49_tt}, 32'h3);
    // Direct mapping write and unmapped places leave the rest alone
    ahb(1'b1, RMAD_INBOUND_MAP_12_LOW, 32'h0000_6000);
    rd(RMAD_TRANSPORT_PORT2_STATUS, link_val[1]);
    rd(RMAD_INBOUND_MAP_12_LOW, 32'h0000_6000);
    ahb(1'b1, 20'h02400, 32'hA5A5_A5A5);
    rd(20'h02400, RMAD_RESET_WORD);
    rd(RMAD_MAP_LO, RMAD_RESET_WORD);
    // Fixed decode when the alias enable is cleared
    ahb(1'b1, RMAD_CTRL_OFS, 32'h0);
    rd(RMAD_CTRL_OFS, 32'h0);
    ahb(1'b1, RMAD_EVENT_PORTWRITE_ENABLE, 32'h1234_5678);
    rd(RMAD_TYPE9_MAP_45_WORD2, link_val[3]);
    rd(RMAD_EVENT_PORTWRITE_ENABLE, 32'h1234_5678);
    ahb(1'b1, RMAD_CTRL_OFS, RMAD_CTRL_RESET);
    // Random offsets across the whole upper window
    for (int k = 0; k < 8; k++)
    begin
      ofs = RMAD_LINK_LO + {9'h0, 9'($urandom_range(0, 383)), 2'h0};
      d = $urandom();
      if (ofs == RMAD_TRANSPORT_PORT1_STATUS || ofs == RMAD_EVENT_MULTICAST_PORT_STATUS)
        d[14:13] = 2'h3;
      ahb(1'b1, ofs, d);
      rd(map_of(ofs), d);
    end
    @(negedge ref_clk);
    check({30'h0, map01_tt}, 32'h3);
    check({30'h0, map49_tt}, 32'h3);
    // Receive context pool; a release still counts when the claim finds it empty
    ctx(1'b1, 1'b0, 17, 5'h00);
    ctx(1'b1, 1'b1, 1, 5'h01);
    ctx(1'b0, 1'b1, 1, 5'h02);
    ctx(1'b1, 1'b1, 1, 5'h02);
    rd(RMAD_STAT_OFS, 32'h2);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    ctx(1'b1, 1'b0, 3, 5'h02);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    ctx(1'b0, 1'b1, 20, 5'h10);
    repeat (2) @(posedge ref_clk);
    check(exp_q.size(), 32'h0);
    final_report();
  end
endmodule // tb
`default_nettype wire
